/* rtl/piu_dev.sv */
// piu_dev: eight-input programmable priority interrupt unit, device end
//
// How it works
// - software names lowest level; next one ranks highest
// - status bit n shows line n; zero highest
// - readable, writable mask; set bit blocks input
// - in-service bit per level, cleared by end commands
// - request bits; acknowledge clears highest pending one
// - requests recorded whatever the mask says
// - host low port clears a0, high port sets
// - ready for init at reset; two or three words
// - low port with bit 4 starts init
// - word one bits 7..5 give address a7..a5; only bits 7..6 used at eight spacing
// - word one bit 3 selects level sensing
// - word one bit 2: four or eight spacing
// - software sets single-controller bit in word one
// - word one bit 0 asks word four, else defaults
// - next high-port byte gives address a15..a8
// - software skips word three, single controller only
// - word four sets auto end and nesting modes
// - high port after init loads mask, reset zero
// - low port bits 3,4 low is operation word two
// - operation word two bit 2 is level msb
// - operation word two bits 7..5 pick the command
// - acknowledge gives call opcode then two vector bytes
module piu_dev
    import piu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    piu_if.dev link,
    input wire logic [7:0] request_inputs,
    output logic initialised
);

    typedef struct packed {
        piu_init_e st;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
        logic [7:0] pending_request_bits;
        logic [7:0] in_service_bits;
        logic [7:0] input_mask;
        logic [2:0] vec_lo;
        logic [7:0] vec_hi;
        logic ltim;
        logic adi;
        logic need4;
        logic automatic_service_end;
        logic sfnm;
        logic rot_a;
        logic [2:0] lowest;
        logic read_isr;
        logic [1:0] ack_cnt;
        logic [2:0] ack_lvl;
        logic [7:0] rdata;
        logic irq;
    } piu_dev_s;

    localparam piu_dev_s DEV_RST = '{
        st: ST_WAIT_W1, sync1: 8'h00, sync2: 8'h00, prev: 8'h00, pending_request_bits: 8'h00,
        in_service_bits: 8'h00, input_mask: MASK_RST, vec_lo: 3'h0, vec_hi: 8'h00, ltim: 1'b0,
        adi: 1'b0, need4: 1'b0, automatic_service_end: 1'b0, sfnm: 1'b0, rot_a: 1'b0,
        lowest: LOWEST_RST, read_isr: 1'b0, ack_cnt: 2'h0, ack_lvl: 3'h0,
        rdata: IDLE_DATA, irq: 1'b0
    };

    piu_dev_s r;
    piu_dev_s nxt;

    logic [7:0] pending;
    logic [3:0] req_pick;
    logic [3:0] srv_pick;
    logic [2:0] lvl_sel;
    logic allowed;
    logic [15:0] vector;
    logic [7:0] rise;

    ////////////////////////////////////////////////////////////////////////////
    // priority resolution

    always_comb begin
        pending = r.pending_request_bits & ~r.input_mask;
        req_pick = piu_pick(pending, r.lowest);
        srv_pick = piu_pick(r.in_service_bits, r.lowest);
        // nested: only a strictly higher level may interrupt a service in progress,
        // fully nested also lets the same level through
        if (!srv_pick[3]) begin
            allowed = req_pick[3];
        end else if (r.sfnm) begin
            allowed = req_pick[3]
                && piu_rank(req_pick[2:0], r.lowest) <= piu_rank(srv_pick[2:0], r.lowest);
        end else begin
            allowed = req_pick[3]
                && piu_rank(req_pick[2:0], r.lowest) < piu_rank(srv_pick[2:0], r.lowest);
        end
        lvl_sel = link.bus_wdata[2:0];
        rise = r.sync2 & ~r.prev;
        if (r.adi) begin
            vector = {r.vec_hi, r.vec_lo, r.ack_lvl, 2'b00};
        end else begin
            vector = {r.vec_hi, r.vec_lo[2:1], r.ack_lvl, 3'b000};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt = r;
        // pins cross into the clock domain through two flops
        nxt.sync1 = request_inputs;
        nxt.sync2 = r.sync1;
        nxt.prev = r.sync2;

        // request capture ignores the mask
        if (r.ltim) begin
            nxt.pending_request_bits = r.sync2;
        end else begin
            nxt.pending_request_bits = r.pending_request_bits | rise;
        end

        // acknowledge sequence: opcode, low byte, high byte
        if (link.bus_ack) begin
            case (r.ack_cnt)
                2'h0: begin
                    nxt.rdata = CALL_OPCODE;
                    nxt.ack_cnt = 2'h1;
                    if (req_pick[3]) begin
                        nxt.ack_lvl = req_pick[2:0];
                        nxt.in_service_bits[req_pick[2:0]] = 1'b1;
                        // a fresh edge landing in the acknowledge cycle wins over the clear
                        nxt.pending_request_bits[req_pick[2:0]] = rise[req_pick[2:0]] && !r.ltim;
                    end else begin
                        // nothing pending: answer as if line seven asked
                        nxt.ack_lvl = 3'h7;
                    end
                end
                2'h1: begin
                    nxt.rdata = vector[7:0];
                    nxt.ack_cnt = 2'h2;
                end
                default: begin
                    nxt.rdata = vector[15:8];
                    nxt.ack_cnt = 2'h0;
                    if (r.automatic_service_end) begin
                        nxt.in_service_bits[r.ack_lvl] = 1'b0;
                        if (r.rot_a) begin
                            nxt.lowest = r.ack_lvl;
                        end
                    end
                end
            endcase
        end

        if (link.bus_rd) begin
            if (link.bus_a0 == PORT_HIGH) begin
                nxt.rdata = r.input_mask;
            end else begin
                nxt.rdata = r.read_isr ? r.in_service_bits : r.pending_request_bits;
            end
        end

        if (link.bus_wr) begin
            if (link.bus_a0 == PORT_LOW && link.bus_wdata[W1_START]) begin
                nxt.st = ST_WAIT_W2;
                nxt.vec_lo = link.bus_wdata[W1_VEC_HI:W1_VEC_LO];
                nxt.ltim = link.bus_wdata[W1_LTIM];
                nxt.adi = link.bus_wdata[W1_ADI];
                nxt.need4 = link.bus_wdata[W1_NEED4];
                nxt.automatic_service_end = 1'b0;
                nxt.sfnm = 1'b0;
                nxt.input_mask = MASK_RST;
                nxt.in_service_bits = 8'h00;
                nxt.pending_request_bits = 8'h00;
                nxt.rot_a = 1'b0;
                nxt.lowest = LOWEST_RST;
                nxt.read_isr = 1'b0;
                nxt.ack_cnt = 2'h0;
            end else begin
                case (r.st)
                    ST_WAIT_W2: begin
                        if (link.bus_a0 == PORT_HIGH) begin
                            nxt.vec_hi = link.bus_wdata;
                            nxt.st = r.need4 ? ST_WAIT_W4 : ST_RUN;
                        end
                    end
                    ST_WAIT_W4: begin
                        if (link.bus_a0 == PORT_HIGH) begin
                            nxt.automatic_service_end = link.bus_wdata[W4_AUTOMATIC_SERVICE_END];
                            nxt.sfnm = link.bus_wdata[W4_SFNM];
                            nxt.st = ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (link.bus_a0 == PORT_HIGH) begin
                            nxt.input_mask = link.bus_wdata;
                        end else if (link.bus_wdata[OPW_SEL_HI:OPW_SEL_LO] == SEL_OPW2) begin
                            case (link.bus_wdata[7:5])
                                CMD_ROT_A_CLR: nxt.rot_a = 1'b0;
                                CMD_ROT_A_SET: nxt.rot_a = 1'b1;
                                CMD_NS_EOI: begin
                                    if (srv_pick[3]) begin
                                        nxt.in_service_bits[srv_pick[2:0]] = 1'b0;
                                    end
                                end
                                CMD_NS_EOI_ROT: begin
                                    if (srv_pick[3]) begin
                                        nxt.in_service_bits[srv_pick[2:0]] = 1'b0;
                                        nxt.lowest = srv_pick[2:0];
                                    end
                                end
                                CMD_SP_EOI: nxt.in_service_bits[lvl_sel] = 1'b0;
                                CMD_SET_LOW: nxt.lowest = lvl_sel;
                                CMD_SP_EOI_ROT: begin
                                    nxt.in_service_bits[lvl_sel] = 1'b0;
                                    nxt.lowest = lvl_sel;
                                end
                                default: nxt.rot_a = r.rot_a;
                            endcase
                        end else if (link.bus_wdata[OPW_SEL_HI:OPW_SEL_LO] == SEL_OPW3) begin
                            if (link.bus_wdata[OPW3_RRD]) begin
                                nxt.read_isr = link.bus_wdata[OPW3_RIS];
                            end
                        end
                    end
                    default: nxt.st = r.st;
                endcase
            end
        end

        // the request drops while an acknowledge is under way so it is not taken twice
        nxt.irq = (nxt.st == ST_RUN) && allowed && !link.bus_ack && (r.ack_cnt == 2'h0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= DEV_RST;
        end else if (ce) begin
            r <= nxt;
        end
    end

    assign link.bus_rdata = r.rdata;
    assign link.int_req = r.irq;
    assign initialised = (r.st == ST_RUN);

endmodule : piu_dev

/* rtl/piu_host.sv */
// piu_host: apb-controlled host end that drives the interrupt unit's byte ports
module piu_host
    import piu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    piu_if.host link
);

    typedef struct packed {
        piu_host_e st;
        logic wr;
        logic rd;
        logic a0;
        logic [7:0] wdata;
        logic ack;
        logic acking;
        logic [1:0] ack_left;
        logic [7:0] last;
        logic [23:0] vec;
    } piu_host_s;

    localparam piu_host_s HOST_RST = '{
        st: HS_IDLE, wr: 1'b0, rd: 1'b0, a0: 1'b0, wdata: 8'h00, ack: 1'b0,
        acking: 1'b0, ack_left: 2'h0, last: 8'h00, vec: 24'h000000
    };

    piu_host_s r;
    piu_host_s nxt;
    logic access;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave and link sequencing

    always_comb begin
        nxt = r;
        access = psel && penable && ce;
        mapped = (paddr == HOST_CMD) || (paddr == HOST_ACK)
            || (paddr == HOST_STAT) || (paddr == HOST_VEC);
        pready = ce;
        pslverr = access && !mapped;
        case (paddr)
            HOST_STAT: prdata = {16'h0000, r.last, 6'h00, link.int_req, r.st != HS_IDLE};
            HOST_VEC: prdata = {8'h00, r.vec};
            default: prdata = 32'h00000000;
        endcase

        case (r.st)
            HS_IDLE: begin
                // writes arriving while a transfer runs are dropped, software polls busy
                if (access && pwrite && paddr == HOST_CMD) begin
                    nxt.a0 = pwdata[CMD_A0];
                    nxt.wdata = pwdata[7:0];
                    nxt.rd = pwdata[CMD_RD];
                    nxt.wr = !pwdata[CMD_RD];
                    nxt.st = HS_STROBE;
                end else if (access && pwrite && paddr == HOST_ACK) begin
                    nxt.ack = 1'b1;
                    nxt.acking = 1'b1;
                    nxt.ack_left = ACK_BYTES - 2'h1;
                    nxt.st = HS_STROBE;
                end
            end
            HS_STROBE: begin
                nxt.wr = 1'b0;
                nxt.rd = 1'b0;
                nxt.ack = 1'b0;
                nxt.st = HS_CAPT;
            end
            HS_CAPT: begin
                if (r.acking) begin
                    nxt.vec = {link.bus_rdata, r.vec[23:8]};
                    if (r.ack_left != 2'h0) begin
                        nxt.ack_left = r.ack_left - 2'h1;
                        nxt.ack = 1'b1;
                        nxt.st = HS_STROBE;
                    end else begin
                        nxt.acking = 1'b0;
                        nxt.st = HS_IDLE;
                    end
                end else begin
                    nxt.last = link.bus_rdata;
                    nxt.st = HS_IDLE;
                end
            end
            default: nxt.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= HOST_RST;
        end else if (ce) begin
            r <= nxt;
        end
    end

    assign link.bus_wr = r.wr;
    assign link.bus_rd = r.rd;
    assign link.bus_a0 = r.a0;
    assign link.bus_wdata = r.wdata;
    assign link.bus_ack = r.ack;

endmodule : piu_host

/* rtl/piu_if.sv */
// piu_if: byte port link between the host end and the interrupt unit
interface piu_if (
    input wire logic sys_clk
);
    logic bus_wr;
    logic bus_rd;
    logic bus_a0;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic bus_ack;
    logic int_req;

    modport dev (
        input bus_wr, bus_rd, bus_a0, bus_wdata, bus_ack,
        output bus_rdata, int_req
    );
    modport host (
        output bus_wr, bus_rd, bus_a0, bus_wdata, bus_ack,
        input bus_rdata, int_req
    );
endinterface : piu_if

/* rtl/piu_pkg.sv */
// piu_pkg: constants, types and priority helpers for the priority interrupt unit
package piu_pkg;
    // device port selection (internal address bit)
    localparam logic PORT_LOW = 1'b0;
    localparam logic PORT_HIGH = 1'b1;
    // first init word fields
    localparam int W1_START = 4;
    localparam int W1_LTIM = 3;
    localparam int W1_ADI = 2;
    localparam int W1_SNGL = 1;
    localparam int W1_NEED4 = 0;
    localparam int W1_VEC_HI = 7;
    localparam int W1_VEC_LO = 5;
    // fourth init word fields
    localparam int W4_AUTOMATIC_SERVICE_END = 1;
    localparam int W4_SFNM = 4;
    // low-port command selector bits and operation word 3 fields
    localparam int OPW_SEL_HI = 4;
    localparam int OPW_SEL_LO = 3;
    localparam logic [1:0] SEL_OPW2 = 2'h0;
    localparam logic [1:0] SEL_OPW3 = 2'h1;
    localparam int OPW3_RIS = 0;
    localparam int OPW3_RRD = 1;
    // operation word two command field {b7,b6,b5}
    localparam logic [2:0] CMD_ROT_A_CLR = 3'h0;
    localparam logic [2:0] CMD_NS_EOI = 3'h1;
    localparam logic [2:0] CMD_SP_EOI = 3'h3;
    localparam logic [2:0] CMD_ROT_A_SET = 3'h4;
    localparam logic [2:0] CMD_NS_EOI_ROT = 3'h5;
    localparam logic [2:0] CMD_SET_LOW = 3'h6;
    localparam logic [2:0] CMD_SP_EOI_ROT = 3'h7;
    // reset values and call opcode
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [2:0] LOWEST_RST = 3'h7;
    localparam logic [7:0] CALL_OPCODE = 8'hcd;
    localparam logic [7:0] IDLE_DATA = 8'h00;
    // host register offsets (apb byte addresses), field bits and acknowledge byte count
    localparam logic [7:0] HOST_CMD = 8'h00;
    localparam logic [7:0] HOST_ACK = 8'h04;
    localparam logic [7:0] HOST_STAT = 8'h08;
    localparam logic [7:0] HOST_VEC = 8'h0c;
    localparam int CMD_A0 = 8;
    localparam int CMD_RD = 9;
    localparam int STAT_BUSY = 0;
    localparam int STAT_INT = 1;
    localparam int STAT_DATA = 8;
    localparam logic [1:0] ACK_BYTES = 2'h3;

    typedef enum logic [1:0] {ST_WAIT_W1, ST_WAIT_W2, ST_WAIT_W4, ST_RUN} piu_init_e;
    typedef enum logic [1:0] {HS_IDLE, HS_STROBE, HS_CAPT} piu_host_e;

    // rank of a level, 0 is highest, given the level that currently ranks lowest
    function automatic logic [2:0] piu_rank(input logic [2:0] lvl, input logic [2:0] low);
        piu_rank = lvl - low - 3'h1;
    endfunction : piu_rank

    // highest-ranked set bit: {found, level}
    function automatic logic [3:0] piu_pick(input logic [7:0] v, input logic [2:0] low);
        logic [2:0] idx;
        piu_pick = 4'h0;
        for (int k = 7; k >= 0; k--) begin
            idx = low + 3'h1 + k[2:0];
            if (v[idx]) begin
                piu_pick = {1'b1, idx};
            end
        end
    endfunction : piu_pick
endpackage : piu_pkg

/* testbench/piu_props.sv */
// piu_props: link protocol and acknowledge answer checks between host end and unit
module piu_props
    import piu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_a0,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic int_req
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the init sequence seen on the link; phase 3 waits for word one
    logic [1:0] ack_n_r;
    logic [1:0] phase_r;
    logic need4_r;
    logic [7:0] w1_r;
    logic [7:0] w2_r;
    logic [7:0] mask_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_n_r <= 2'h0;
            phase_r <= 2'h3;
            need4_r <= 1'b0;
            w1_r <= 8'h00;
            w2_r <= 8'h00;
            mask_r <= MASK_RST;
        end else begin
            if (bus_ack) begin
                ack_n_r <= (ack_n_r == 2'h2) ? 2'h0 : ack_n_r + 2'h1;
            end
            if (bus_wr && !bus_a0 && bus_wdata[W1_START]) begin
                phase_r <= 2'h1;
                need4_r <= bus_wdata[W1_NEED4];
                w1_r <= bus_wdata;
                mask_r <= MASK_RST;
            end else if (bus_wr && bus_a0) begin
                if (phase_r == 2'h1) begin
                    w2_r <= bus_wdata;
                    phase_r <= need4_r ? 2'h2 : 2'h0;
                end else if (phase_r == 2'h2) begin
                    phase_r <= 2'h0;
                end else if (phase_r == 2'h0) begin
                    mask_r <= bus_wdata;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_wr_single_pulse: assert property (bus_wr |=> !bus_wr)
        else $error("write strobe longer than one cycle");
    a_rd_single_pulse: assert property (bus_rd |=> !bus_rd)
        else $error("read strobe longer than one cycle");
    a_ack_single_pulse: assert property (bus_ack |=> !bus_ack)
        else $error("acknowledge strobe longer than one cycle");
    a_strobes_exclusive: assert property (!(bus_wr && bus_rd) && !(bus_ack && (bus_wr || bus_rd)))
        else $error("two link strobes at once");
    a_call_first_byte: assert property (bus_ack && ack_n_r == 2'h0 |=> bus_rdata == CALL_OPCODE)
        else $error("first acknowledge byte is not the call opcode");
    a_vector_low_byte: assert property (bus_ack && ack_n_r == 2'h1 |=> (w1_r[W1_ADI] ?
        (bus_rdata[7:5] == w1_r[7:5] && bus_rdata[1:0] == 2'h0) :
        (bus_rdata[7:6] == w1_r[7:6] && bus_rdata[2:0] == 3'h0)))
        else $error("vector low byte does not match base and spacing");
    a_vector_high_byte: assert property (bus_ack && ack_n_r == 2'h2 |=> bus_rdata == w2_r)
        else $error("vector high byte differs from word two");
    a_mask_read_back: assert property (bus_rd && bus_a0 |=> bus_rdata == mask_r)
        else $error("high port read differs from mask written");
    a_rdata_holds: assert property (!bus_rd && !bus_ack |=> $stable(bus_rdata))
        else $error("read byte changed without a strobe");
    a_int_drops_ack: assert property (bus_ack |=> !int_req)
        else $error("interrupt request held during acknowledge");
endmodule : piu_props

/* testbench/piu_test.sv */
// piu_test: self-checking bench for host end and interrupt unit joined by the link
module piu_test
    import piu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] request_inputs = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic initialised;
    int num_errors = 0;
    int n_compared = 0;
    piu_if piu_if_inst (.sys_clk(sys_clk));
    piu_dev piu_dev_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .link(piu_if_inst),
        .request_inputs(request_inputs), .initialised(initialised));
    piu_host piu_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(piu_if_inst));
    piu_props piu_props_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus_wr(piu_if_inst.bus_wr),
        .bus_rd(piu_if_inst.bus_rd), .bus_a0(piu_if_inst.bus_a0),
        .bus_wdata(piu_if_inst.bus_wdata), .bus_rdata(piu_if_inst.bus_rdata),
        .bus_ack(piu_if_inst.bus_ack), .int_req(piu_if_inst.int_req));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic chk8(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check(what, {16'h0, seen}, {16'h0, exp});
    endtask : chk8
    // entered just after a rising edge; the answer is taken at the rising edge
    // that samples pready high, before that edge's own updates land
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        logic rdy;
        rdy = 1'b0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (int i = 0; i < 20 && !rdy; i++) begin
            @(posedge sys_clk);
            rdy = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (!rdy) begin
            num_errors++;
            give_verdict();
        end
    endtask : apb
    task automatic wait_idle(output logic [31:0] st);
        logic e;
        for (int i = 0; i < 20; i++) begin
            apb(HOST_STAT, 1'b0, 32'h0, st, e);
            if (st[STAT_BUSY] === 1'b0) return;
        end
        num_errors++;
        give_verdict();
    endtask : wait_idle
    task automatic dev_op(input logic a0, input logic rd, input logic [7:0] b,
        output logic [7:0] got);
        logic [31:0] r;
        logic e;
        apb(HOST_CMD, 1'b1, {22'h0, rd, a0, b}, r, e);
        wait_idle(r);
        got = r[15:8];
    endtask : dev_op
    task automatic wr(input logic a0, input logic [7:0] b);
        logic [7:0] g;
        dev_op(a0, 1'b0, b, g);
    endtask : wr
    task automatic rd_chk(input string what, input logic a0, input logic [7:0] exp);
        logic [7:0] g;
        dev_op(a0, 1'b1, 8'h00, g);
        chk8(what, g, exp);
    endtask : rd_chk
    task automatic int_chk(input logic exp);
        logic [31:0] r;
        wait_idle(r);
        chk8("int request", {7'h0, r[STAT_INT]}, {7'h0, exp});
    endtask : int_chk
    task automatic ack_chk(input logic [7:0] lo, input logic [7:0] hi);
        logic [31:0] r;
        logic e;
        apb(HOST_ACK, 1'b1, 32'h0, r, e);
        wait_idle(r);
        apb(HOST_VEC, 1'b0, 32'h0, r, e);
        check("vector", r[23:0], {hi, lo, CALL_OPCODE});
    endtask : ack_chk
    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_init();
        wr(PORT_HIGH, 8'h55);
        chk8("init flag", {7'h0, initialised}, 8'h00);
        wr(PORT_LOW, 8'hfe);
        wr(PORT_HIGH, 8'hff);
        chk8("init flag", {7'h0, initialised}, 8'h01);
        rd_chk("mask after init", PORT_HIGH, MASK_RST);
    endtask : s_init
    task automatic s_mask();
        request_inputs <= 8'h01;
        wr(PORT_HIGH, 8'ha5);
        rd_chk("mask", PORT_HIGH, 8'ha5);
        wr(PORT_HIGH, 8'hff);
        int_chk(1'b0);
        wr(PORT_LOW, 8'h0a);
        rd_chk("requests", PORT_LOW, 8'h01);
        wr(PORT_HIGH, 8'h00);
        int_chk(1'b1);
        request_inputs <= 8'h00;
    endtask : s_mask
    task automatic s_nest();
        @(posedge sys_clk);
        request_inputs <= 8'h28;
        // pins pass two sync flops and the request register before they show
        repeat (4) @(posedge sys_clk);
        rd_chk("requests", PORT_LOW, 8'h28);
        ack_chk(8'hec, 8'hff);
        wr(PORT_LOW, 8'h0b);
        rd_chk("in service", PORT_LOW, 8'h08);
        wr(PORT_LOW, 8'h20);
        rd_chk("in service", PORT_LOW, 8'h00);
    endtask : s_nest
    task automatic s_rotate();
        wr(PORT_LOW, 8'hc4);
        ack_chk(8'hf4, 8'hff);
        rd_chk("in service", PORT_LOW, 8'h20);
        wr(PORT_LOW, 8'h65);
        rd_chk("in service", PORT_LOW, 8'h00);
        ack_chk(8'hf4, 8'hff);
        wr(PORT_LOW, 8'ha0);
        ack_chk(8'hec, 8'hff);
        wr(PORT_LOW, 8'he3);
        ack_chk(8'hf4, 8'hff);
        wr(PORT_LOW, 8'h20);
        rd_chk("in service", PORT_LOW, 8'h00);
        wr(PORT_LOW, 8'h80);
        wr(PORT_LOW, 8'h00);
        wr(PORT_LOW, 8'hc7);
        request_inputs <= 8'h00;
    endtask : s_rotate
    task automatic s_edge8();
        wr(PORT_LOW, 8'hb3);
        wr(PORT_HIGH, 8'h12);
        wr(PORT_HIGH, 8'h12);
        rd_chk("mask after word four", PORT_HIGH, 8'h00);
        request_inputs <= 8'h44;
        repeat (4) @(posedge sys_clk);
        ack_chk(8'h90, 8'h12);
        wr(PORT_LOW, 8'h0a);
        rd_chk("edge requests", PORT_LOW, 8'h40);
        wr(PORT_LOW, 8'h0b);
        rd_chk("auto end", PORT_LOW, 8'h00);
        wr(PORT_LOW, 8'h20);
    endtask : s_edge8
    task automatic s_bus();
        logic [31:0] r;
        logic e;
        apb(8'h40, 1'b0, 32'h0, r, e);
        chk8("unmapped error", {7'h0, e}, 8'h01);
    endtask : s_bus
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        s_init();
        s_mask();
        s_nest();
        s_rotate();
        s_edge8();
        s_bus();
        give_verdict();
    end
endmodule : piu_test
